// File: acs_pkg.sv
`default_nettype none
package acs_pkg;
    localparam int COEF_W = 24;
    localparam int MODE_W = 3;
    localparam int FSW_W = 10;
    localparam int TICK_W = 5;
    localparam int PROD_W = 2 * COEF_W + 2;

    // Operating-mode field codes (defaults of the device parameters, except MODE_SINGLE)
    localparam logic [MODE_W-1:0] MODE_CONT = 3'h0;
    localparam logic [MODE_W-1:0] MODE_SINGLE = 3'h1;
    localparam logic [MODE_W-1:0] MODE_IDLE = 3'h2;
    localparam logic [MODE_W-1:0] MODE_PWRDN = 3'h3;
    localparam logic [MODE_W-1:0] MODE_IZS = 3'h4;
    localparam logic [MODE_W-1:0] MODE_IFS = 3'h5;
    localparam logic [MODE_W-1:0] MODE_SZS = 3'h6;
    localparam logic [MODE_W-1:0] MODE_SFS = 3'h7;

    // Settling in output-data-rate periods
    localparam logic [TICK_W-1:0] SETTLE_SINC4 = 5'h04;
    localparam logic [TICK_W-1:0] SETTLE_SINC3 = 5'h03;
    localparam logic [TICK_W-1:0] SETTLE_CHOP = 5'h02;
    localparam int IFS_GAIN_SHIFT = 1;
    localparam int CLKDIV_SHIFT = 1;

    // Reset values and fixed-point layout of the coefficients
    localparam logic [COEF_W-1:0] OFFSET_RST = 24'h800000;
    localparam logic [COEF_W-1:0] FSCALE_RST = 24'h400000;
    localparam int FS_SHIFT = 22;
    localparam logic [COEF_W-1:0] DATA_RST = 24'h000000;
    localparam logic COEF_SEL_OFFSET = 1'b0;
    localparam logic COEF_SEL_FSCALE = 1'b1;
    localparam logic [3:0] IFS_FSW_ALIGN_MASK = 4'hF;

    typedef enum logic [1:0] {REF_EXT, REF_ZERO, REF_FULL} acs_ref_type;
    typedef enum logic [1:0] {CAL_IZS, CAL_IFS, CAL_SZS, CAL_SFS} acs_cal_type;
endpackage : acs_pkg
`default_nettype wire

// File: acs_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface acs_link_if;
    import acs_pkg::*;
    logic cs_n;
    logic mode_we;
    logic [MODE_W-1:0] mode_code;
    logic cfg_chop;
    logic cfg_sinc3;
    logic cfg_gain_hi;
    logic cfg_clk_div;
    logic [FSW_W-1:0] filter_rate_word;
    logic coef_we;
    logic coef_sel;
    logic [COEF_W-1:0] coef_wdata;
    logic [COEF_W-1:0] offset_coef;
    logic [COEF_W-1:0] fscale_coef;
    logic [COEF_W-1:0] data_word;
    logic rdy_bit;
    logic rdy_pin;
    logic rdy_pin_oe_n;

    modport dev (input cs_n, mode_we, mode_code, cfg_chop, cfg_sinc3, cfg_gain_hi, cfg_clk_div,
                 filter_rate_word, coef_we, coef_sel, coef_wdata,
                 output offset_coef, fscale_coef, data_word, rdy_bit, rdy_pin, rdy_pin_oe_n);
    modport host (output cs_n, mode_we, mode_code, cfg_chop, cfg_sinc3, cfg_gain_hi, cfg_clk_div,
                  filter_rate_word, coef_we, coef_sel, coef_wdata,
                  input offset_coef, fscale_coef, data_word, rdy_bit, rdy_pin, rdy_pin_oe_n);
endinterface : acs_link_if
`default_nettype wire

// File: acs_correct.sv
`timescale 1ns/100ps
`default_nettype none
module acs_correct (
    input wire logic clk,
    input wire logic rst,
    input wire logic in_valid,
    input wire logic [acs_pkg::COEF_W-1:0] raw,
    input wire logic [acs_pkg::COEF_W-1:0] offset,
    input wire logic [acs_pkg::COEF_W-1:0] fscale,
    output logic out_valid_r,
    output logic [acs_pkg::COEF_W-1:0] result_r
);
    import acs_pkg::*;
    logic signed [COEF_W:0] diff;
    logic signed [PROD_W-1:0] prod;
    logic signed [PROD_W-1:0] scaled;
    logic [COEF_W-1:0] sat;

    // Offset first, then gain
    assign diff = $signed({1'b0, raw}) - $signed({1'b0, offset});
    // Widen both factors first so the product keeps its upper bits
    assign prod = PROD_W'(diff) * PROD_W'($signed({1'b0, fscale}));
    assign scaled = prod >>> FS_SHIFT;
    assign sat = (scaled < 0) ? '0 :
                 (scaled > $signed({{(PROD_W-COEF_W){1'b0}}, {COEF_W{1'b1}}})) ? {COEF_W{1'b1}} :
                 scaled[COEF_W-1:0];

    always_ff @(posedge clk) begin
        if (rst) begin
            out_valid_r <= 1'b0;
            result_r <= DATA_RST;
        end else begin
            out_valid_r <= in_valid;
            if (in_valid) begin
                result_r <= sat;
            end
        end
    end
endmodule : acs_correct
`default_nettype wire

// File: acs_device.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - Four calibration modes started by mode writes.
// - Result minus offset, then times full-scale.
// - Start raises ready pin and not-ready bit.
// - Done: update coefficient, clear bit, go idle.
// - Internal calibration routes reference to converter.
// - Host applies system level before calibration.
// - Host runs zero-scale before full-scale.
// - Chop off: zero-scale takes filter settling.
// - Chop on: zero-scale takes two periods.
// - Internal full-scale doubles above gain one.
// - System full-scale takes one settling time.
// - Internal full-scale needs filter word multiple 16.
// - Other calibrations accept any filter word.
// - Clock halving doubles internal full-scale time.
// - Host writes coefficients only idle/power-down.
// - Coefficients are 24-bit, readable and writable.
// - Host polls ready bit or pin.
// - Fourth-order filter settles in four periods.
module acs_device #(
    parameter logic [acs_pkg::MODE_W-1:0] CODE_CONT = acs_pkg::MODE_CONT,
    parameter logic [acs_pkg::MODE_W-1:0] CODE_IDLE = acs_pkg::MODE_IDLE,
    parameter logic [acs_pkg::MODE_W-1:0] CODE_PWRDN = acs_pkg::MODE_PWRDN,
    parameter logic [acs_pkg::MODE_W-1:0] CODE_IZS = acs_pkg::MODE_IZS,
    parameter logic [acs_pkg::MODE_W-1:0] CODE_IFS = acs_pkg::MODE_IFS,
    parameter logic [acs_pkg::MODE_W-1:0] CODE_SZS = acs_pkg::MODE_SZS,
    parameter logic [acs_pkg::MODE_W-1:0] CODE_SFS = acs_pkg::MODE_SFS
) (
    input wire logic clk,
    input wire logic rst,
    acs_link_if.dev link,
    input wire logic conv_tick,
    input wire logic [acs_pkg::COEF_W-1:0] raw_sample,
    output acs_pkg::acs_ref_type ref_sel_r,
    output logic cal_busy_r,
    output logic data_new_r,
    output logic [acs_pkg::MODE_W-1:0] mode_r
);
    import acs_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_CONV, ST_CAL, ST_PWRDN} acs_state_type;

    acs_state_type state_r;
    acs_state_type state_nxt;
    acs_cal_type kind_r;
    acs_cal_type kind_nxt;
    logic [TICK_W-1:0] cnt_r;
    logic [TICK_W-1:0] cnt_nxt;
    logic [COEF_W-1:0] offset_r;
    logic [COEF_W-1:0] fscale_r;
    logic [COEF_W-1:0] data_r;
    logic rdy_bit_r;
    logic rdy_pin_r;
    logic oe_n_r;
    logic [MODE_W-1:0] mode_nxt;
    logic is_cal_code;
    logic cal_last;
    logic cal_done;
    logic coef_ok;
    logic corr_valid;
    logic [COEF_W-1:0] corr_result;
    logic [COEF_W:0] span;
    logic [COEF_W-1:0] span_sat;

    function automatic logic [TICK_W-1:0] settle_ticks(input acs_cal_type kind, input logic chop,
                                                       input logic sinc3, input logic gain_hi,
                                                       input logic clk_div);
        logic [TICK_W-1:0] t;
        t = chop ? SETTLE_CHOP : (sinc3 ? SETTLE_SINC3 : SETTLE_SINC4);
        if (kind == CAL_IFS) begin
            if (gain_hi) begin
                t = t << IFS_GAIN_SHIFT;
            end
            if (clk_div) begin
                t = t << CLKDIV_SHIFT;
            end
        end
        return t;
    endfunction : settle_ticks

    // Any calibration code is accepted regardless of filter word
    assign is_cal_code = (link.mode_code == CODE_IZS) || (link.mode_code == CODE_IFS) ||
                         (link.mode_code == CODE_SZS) || (link.mode_code == CODE_SFS);
    assign kind_nxt = (link.mode_code == CODE_IZS) ? CAL_IZS :
                      (link.mode_code == CODE_IFS) ? CAL_IFS :
                      (link.mode_code == CODE_SZS) ? CAL_SZS : CAL_SFS;
    assign cal_last = (state_r == ST_CAL) && conv_tick && (cnt_r == TICK_W'(1));
    assign cal_done = cal_last && !link.mode_we;
    assign coef_ok = link.coef_we && ((state_r == ST_IDLE) || (state_r == ST_PWRDN)) && !link.mode_we;

    // Full-scale coefficient is the measured span above offset
    assign span = {1'b0, raw_sample} - {1'b0, offset_r};
    assign span_sat = span[COEF_W] ? '0 : span[COEF_W-1:0];

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        mode_nxt = mode_r;
        if (link.mode_we) begin
            mode_nxt = link.mode_code;
            if (is_cal_code) begin
                state_nxt = ST_CAL;
                cnt_nxt = settle_ticks(kind_nxt, link.cfg_chop, link.cfg_sinc3, link.cfg_gain_hi,
                                       link.cfg_clk_div);
            end else if (link.mode_code == CODE_CONT) begin
                state_nxt = ST_CONV;
            end else if (link.mode_code == CODE_PWRDN) begin
                state_nxt = ST_PWRDN;
            end else begin
                state_nxt = ST_IDLE;
            end
        end else begin
            case (state_r)
                ST_CAL: begin
                    if (cal_done) begin
                        state_nxt = ST_IDLE;
                        mode_nxt = CODE_IDLE;
                    end else if (conv_tick) begin
                        cnt_nxt = cnt_r - TICK_W'(1);
                    end
                end
                ST_IDLE, ST_CONV, ST_PWRDN: begin
                    state_nxt = state_r;
                end
                default: begin
                    state_nxt = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= ST_IDLE;
            kind_r <= CAL_IZS;
            cnt_r <= '0;
            mode_r <= MODE_IDLE;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            mode_r <= mode_nxt;
            if (link.mode_we && is_cal_code) begin
                kind_r <= kind_nxt;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            offset_r <= OFFSET_RST;
            fscale_r <= FSCALE_RST;
        end else if (cal_done && ((kind_r == CAL_IZS) || (kind_r == CAL_SZS))) begin
            offset_r <= raw_sample;
        end else if (cal_done) begin
            fscale_r <= span_sat;
        end else if (coef_ok && (link.coef_sel == COEF_SEL_OFFSET)) begin
            offset_r <= link.coef_wdata;
        end else if (coef_ok) begin
            fscale_r <= link.coef_wdata;
        end
    end

    acs_correct acs_correct_inst (
        .clk(clk),
        .rst(rst),
        .in_valid(conv_tick && (state_r == ST_CONV) && !link.mode_we),
        .raw(raw_sample),
        .offset(offset_r),
        .fscale(fscale_r),
        .out_valid_r(corr_valid),
        .result_r(corr_result)
    );

    always_ff @(posedge clk) begin
        if (rst) begin
            data_r <= DATA_RST;
            data_new_r <= 1'b0;
        end else begin
            data_new_r <= corr_valid;
            if (corr_valid) begin
                data_r <= corr_result;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdy_bit_r <= 1'b1;
            rdy_pin_r <= 1'b1;
            oe_n_r <= 1'b1;
            ref_sel_r <= REF_EXT;
            cal_busy_r <= 1'b0;
        end else begin
            oe_n_r <= link.cs_n;
            if (link.mode_we && is_cal_code) begin
                rdy_bit_r <= 1'b1;
                rdy_pin_r <= 1'b1;
                cal_busy_r <= 1'b1;
                ref_sel_r <= (kind_nxt == CAL_IZS) ? REF_ZERO :
                             (kind_nxt == CAL_IFS) ? REF_FULL : REF_EXT;
            end else if (link.mode_we) begin
                cal_busy_r <= 1'b0;
                ref_sel_r <= REF_EXT;
                rdy_bit_r <= 1'b1;
                rdy_pin_r <= 1'b1;
            end else if (cal_done || corr_valid) begin
                rdy_bit_r <= 1'b0;
                rdy_pin_r <= 1'b0;
                cal_busy_r <= 1'b0;
                ref_sel_r <= REF_EXT;
            end
        end
    end

    assign link.offset_coef = offset_r;
    assign link.fscale_coef = fscale_r;
    assign link.data_word = data_r;
    assign link.rdy_bit = rdy_bit_r;
    assign link.rdy_pin = rdy_pin_r;
    assign link.rdy_pin_oe_n = oe_n_r;
endmodule : acs_device
`default_nettype wire

// File: acs_host.sv
`timescale 1ns/100ps
`default_nettype none
module acs_host (
    input wire logic clk,
    input wire logic rst,
    acs_link_if.host link,
    input wire logic cmd_valid,
    input wire logic [acs_pkg::MODE_W-1:0] cmd_mode,
    input wire logic cmd_with_zero,
    input wire logic chop_in,
    input wire logic sinc3_in,
    input wire logic gain_hi_in,
    input wire logic supply_low,
    input wire logic [acs_pkg::FSW_W-1:0] filter_word_in,
    input wire logic cw_valid,
    input wire logic cw_sel,
    input wire logic [acs_pkg::COEF_W-1:0] cw_data,
    output logic busy_r,
    output logic done_r,
    output logic refused_r,
    output acs_pkg::acs_ref_type apply_level_r
);
    import acs_pkg::*;

    typedef enum logic [2:0] {H_IDLE, H_START, H_WAIT_HI, H_WAIT_LO, H_NEXT} acs_hstate_type;

    acs_hstate_type st_r;
    logic [MODE_W-1:0] mode_r;
    logic [MODE_W-1:0] pend_r;
    logic pend_valid_r;
    logic mode_we_r;
    logic cs_n_r;
    logic clk_div_r;
    logic coef_we_r;
    logic is_fs;
    logic is_zs;
    logic fsw_bad;
    logic seen_lo;

    assign is_fs = (cmd_mode == MODE_IFS) || (cmd_mode == MODE_SFS);
    assign is_zs = (cmd_mode == MODE_IZS) || (cmd_mode == MODE_SZS);
    assign fsw_bad = (cmd_mode == MODE_IFS) && ((filter_word_in[3:0] & IFS_FSW_ALIGN_MASK) != 4'h0);
    assign seen_lo = !link.rdy_pin_oe_n && !link.rdy_pin;

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r <= H_IDLE;
            mode_r <= MODE_IDLE;
            pend_r <= MODE_IDLE;
            pend_valid_r <= 1'b0;
            mode_we_r <= 1'b0;
            cs_n_r <= 1'b1;
            clk_div_r <= 1'b0;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            refused_r <= 1'b0;
            apply_level_r <= REF_EXT;
        end else begin
            mode_we_r <= 1'b0;
            done_r <= 1'b0;
            refused_r <= 1'b0;
            case (st_r)
                H_IDLE: begin
                    // Continuous mode finishes at its first ready-low
                    if (cmd_valid && (fsw_bad || !(is_fs || is_zs || cmd_mode == MODE_CONT))) begin
                        refused_r <= 1'b1;
                    end else if (cmd_valid) begin
                        busy_r <= 1'b1;
                        cs_n_r <= 1'b0;
                        if (is_fs && cmd_with_zero) begin
                            mode_r <= (cmd_mode == MODE_IFS) ? MODE_IZS : MODE_SZS;
                            pend_r <= cmd_mode;
                            pend_valid_r <= 1'b1;
                        end else begin
                            mode_r <= cmd_mode;
                        end
                        st_r <= H_NEXT;
                    end
                end
                H_NEXT: begin
                    apply_level_r <= (mode_r == MODE_SZS) ? REF_ZERO :
                                     (mode_r == MODE_SFS) ? REF_FULL : REF_EXT;
                    clk_div_r <= (mode_r == MODE_IFS) && supply_low;
                    st_r <= H_START;
                end
                H_START: begin
                    mode_we_r <= 1'b1;
                    st_r <= H_WAIT_HI;
                end
                H_WAIT_HI: begin
                    if (link.rdy_pin) begin
                        st_r <= H_WAIT_LO;
                    end
                end
                H_WAIT_LO: begin
                    if (seen_lo && pend_valid_r) begin
                        mode_r <= pend_r;
                        pend_valid_r <= 1'b0;
                        st_r <= H_NEXT;
                    end else if (seen_lo) begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                        cs_n_r <= 1'b1;
                        apply_level_r <= REF_EXT;
                        st_r <= H_IDLE;
                    end
                end
                default: begin
                    st_r <= H_IDLE;
                end
            endcase
        end
    end

    // Coefficient writes only while no calibration is in flight
    always_ff @(posedge clk) begin
        if (rst) begin
            coef_we_r <= 1'b0;
        end else begin
            coef_we_r <= cw_valid && (st_r == H_IDLE) && !cmd_valid;
        end
    end

    assign link.cs_n = cs_n_r;
    assign link.mode_we = mode_we_r;
    assign link.mode_code = mode_r;
    assign link.cfg_chop = chop_in;
    assign link.cfg_sinc3 = sinc3_in;
    assign link.cfg_gain_hi = gain_hi_in;
    assign link.cfg_clk_div = clk_div_r;
    assign link.filter_rate_word = filter_word_in;
    assign link.coef_we = coef_we_r;
    assign link.coef_sel = cw_sel;
    assign link.coef_wdata = cw_data;
endmodule : acs_host
`default_nettype wire

// File: acs_link_properties.sv
`timescale 1ns/100ps
`default_nettype none
module acs_link_properties (
    input wire logic clk,
    input wire logic rst,
    input wire logic cs_n,
    input wire logic mode_we,
    input wire logic [acs_pkg::MODE_W-1:0] mode_code,
    input wire logic [acs_pkg::FSW_W-1:0] filter_rate_word,
    input wire logic coef_we,
    input wire logic coef_sel,
    input wire logic [acs_pkg::COEF_W-1:0] coef_wdata,
    input wire logic [acs_pkg::COEF_W-1:0] offset_coef,
    input wire logic [acs_pkg::COEF_W-1:0] fscale_coef,
    input wire logic rdy_bit,
    input wire logic rdy_pin,
    input wire logic rdy_pin_oe_n
);
    import acs_pkg::*;
    wire logic cal_code;
    wire logic idle_write;
    assign cal_code = mode_code inside {MODE_IZS, MODE_IFS, MODE_SZS, MODE_SFS};
    assign idle_write = coef_we && !mode_we && !rdy_bit;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence cal_write;
        mode_we && cal_code;
    endsequence
    sequence rdy_raised;
        rdy_bit && rdy_pin;
    endsequence

    AST_START_RDY: assert property (cal_write |=> rdy_raised)
        else $error("ready not raised after calibration start");
    AST_PIN_BIT: assert property (rdy_pin == rdy_bit)
        else $error("ready pin and ready bit disagree");
    AST_OE_FOLLOW: assert property (rdy_pin_oe_n == $past(cs_n))
        else $error("ready pin driven without chip select");
    AST_COEF_HOLD: assert property ((rdy_bit && $past(rdy_bit) && !$past(coef_we)) |->
        ($stable(offset_coef) && $stable(fscale_coef)))
        else $error("coefficient changed while calibration pending");
    AST_WR_OFFSET: assert property ((idle_write && coef_sel == COEF_SEL_OFFSET) |=>
        offset_coef == $past(coef_wdata))
        else $error("offset coefficient write lost");
    AST_WR_FSCALE: assert property ((idle_write && coef_sel == COEF_SEL_FSCALE) |=>
        fscale_coef == $past(coef_wdata))
        else $error("full-scale coefficient write lost");
    AST_MODE_CS: assert property (mode_we |-> !cs_n)
        else $error("mode write without chip select");
    AST_WE_PULSE: assert property (mode_we |=> !mode_we)
        else $error("mode write longer than one cycle");
    AST_IFS_ALIGN: assert property ((mode_we && mode_code == MODE_IFS) |-> filter_rate_word[3:0] == 4'h0)
        else $error("internal full-scale start with unaligned filter word");
    AST_RDY_CAUSE: assert property ($rose(rdy_bit) |-> $past(mode_we))
        else $error("ready bit rose without mode write");
endmodule : acs_link_properties
`default_nettype wire

// File: adc_calibration_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_calibration_sequencer_tb;
    import acs_pkg::*;
    logic clk, rst, conv_tick, cmd_valid, cmd_with_zero, chop_in, sinc3_in, gain_hi_in, supply_low;
    logic cw_valid, cw_sel, cal_busy_r, busy_r, done_r, refused_r, data_new_r;
    logic [COEF_W-1:0] raw_sample, cw_data, word_seen;
    logic [MODE_W-1:0] cmd_mode, mode_r, last_code, prev_code;
    logic [FSW_W-1:0] filter_word_in;
    acs_ref_type ref_sel_r, apply_level_r, ref_seen, lvl_seen;
    logic [7:0] ticks;
    logic [2:0] tdiv;
    int miscompares, comparisons;

    acs_link_if lk();
    acs_device acs_device_inst (.clk(clk), .rst(rst), .link(lk), .conv_tick(conv_tick), .raw_sample(raw_sample),
        .ref_sel_r(ref_sel_r), .cal_busy_r(cal_busy_r), .data_new_r(data_new_r), .mode_r(mode_r));
    acs_host acs_host_inst (.clk(clk), .rst(rst), .link(lk), .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
        .cmd_with_zero(cmd_with_zero), .chop_in(chop_in), .sinc3_in(sinc3_in), .gain_hi_in(gain_hi_in),
        .supply_low(supply_low), .filter_word_in(filter_word_in), .cw_valid(cw_valid), .cw_sel(cw_sel),
        .cw_data(cw_data), .busy_r(busy_r), .done_r(done_r), .refused_r(refused_r), .apply_level_r(apply_level_r));
    acs_link_properties acs_link_properties_inst (.clk(clk), .rst(rst), .cs_n(lk.cs_n), .mode_we(lk.mode_we),
        .mode_code(lk.mode_code), .filter_rate_word(lk.filter_rate_word), .coef_we(lk.coef_we),
        .coef_sel(lk.coef_sel), .coef_wdata(lk.coef_wdata), .offset_coef(lk.offset_coef),
        .fscale_coef(lk.fscale_coef), .rdy_bit(lk.rdy_bit), .rdy_pin(lk.rdy_pin), .rdy_pin_oe_n(lk.rdy_pin_oe_n));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // One output-data-rate period every five clocks
    always @(posedge clk) begin
        tdiv <= (tdiv == 3'h4) ? 3'h0 : tdiv + 3'h1;
        conv_tick <= (tdiv == 3'h4);
        if (lk.mode_we) begin
            ticks <= 8'h00;
            prev_code <= last_code;
            last_code <= lk.mode_code;
            lvl_seen <= apply_level_r;
        end else if (conv_tick && lk.rdy_bit) begin
            ticks <= ticks + 8'h01;
        end
        if (cal_busy_r) begin
            ref_seen <= ref_sel_r;
        end
        if (data_new_r) begin
            word_seen <= lk.data_word;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            miscompares++;
        end
    endtask : chk

    task automatic final_report();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    task automatic issue(input logic [2:0] code, input logic wz, ch, s3, gh, sl, input logic [9:0] fw,
                         input logic [23:0] raw);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_mode <= code;
        cmd_with_zero <= wz;
        chop_in <= ch;
        sinc3_in <= s3;
        gain_hi_in <= gh;
        supply_low <= sl;
        filter_word_in <= fw;
        raw_sample <= raw;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
    endtask : issue

    task automatic cal(input logic [2:0] code, input logic wz, ch, s3, gh, sl, input logic [9:0] fw,
                       input logic [23:0] raw, input logic [7:0] n, input acs_ref_type rf,
                       input logic [23:0] ofs, fs);
        int i;
        issue(code, wz, ch, s3, gh, sl, fw, raw);
        chk(busy_r, 1);
        for (i = 0; i < 3000 && done_r !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(done_r, 1);
        chk(ticks, n);
        chk(ref_seen, rf);
        chk(lk.offset_coef, ofs);
        chk(lk.fscale_coef, fs);
        chk({lk.rdy_bit, mode_r, busy_r}, {1'b0, MODE_IDLE, 1'b0});
        if (code == MODE_SZS || code == MODE_SFS) begin
            chk(lvl_seen, (code == MODE_SZS) ? REF_ZERO : REF_FULL);
        end
    endtask : cal

    task automatic refuse(input logic [2:0] code, input logic [9:0] fw);
        int i;
        logic seen;
        seen = 1'b0;
        issue(code, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, fw, 24'h0);
        for (i = 0; i < 4; i++) begin
            seen = seen | (refused_r === 1'b1);
            @(posedge clk);
            #1;
        end
        chk(seen, 1);
        chk(lk.rdy_bit, 0);
    endtask : refuse

    task automatic cw(input logic sel, input logic [23:0] data);
        @(posedge clk);
        cw_valid <= 1'b1;
        cw_sel <= sel;
        cw_data <= data;
        @(posedge clk);
        cw_valid <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk(sel ? lk.fscale_coef : lk.offset_coef, data);
    endtask : cw

    // Continuous conversion; want is the corrected word
    task automatic conv(input logic [23:0] raw, input logic [23:0] want);
        int i;
        issue(MODE_CONT, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 10'h060, raw);
        for (i = 0; i < 40 && done_r !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        chk(done_r, 1);
        chk(word_seen, want);
        chk(lk.data_word, want);
    endtask : conv

    initial begin
        {rst, conv_tick, cmd_valid, cmd_with_zero, chop_in, sinc3_in, gain_hi_in, supply_low} = 8'hFF;
        {conv_tick, cmd_valid, cmd_with_zero, chop_in, sinc3_in, gain_hi_in, supply_low} = 7'h00;
        {cw_valid, cw_sel, tdiv, ticks} = 13'h0000;
        raw_sample = 24'h000000;
        cw_data = 24'h000000;
        cmd_mode = MODE_IDLE;
        filter_word_in = 10'h060;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk(lk.offset_coef, OFFSET_RST);
        chk(lk.fscale_coef, FSCALE_RST);
        chk(lk.data_word, DATA_RST);
        chk({lk.rdy_bit, mode_r}, {1'b1, MODE_IDLE});
        cal(MODE_IZS, 0, 0, 0, 0, 0, 10'h060, 24'h100000, 8'd4, REF_ZERO, 24'h100000, FSCALE_RST);
        cal(MODE_SZS, 0, 0, 1, 0, 0, 10'h061, 24'h120000, 8'd3, REF_EXT, 24'h120000, FSCALE_RST);
        cal(MODE_SZS, 0, 1, 0, 0, 0, 10'h061, 24'h110000, 8'd2, REF_EXT, 24'h110000, FSCALE_RST);
        cal(MODE_IZS, 0, 1, 0, 0, 0, 10'h060, 24'h100000, 8'd2, REF_ZERO, 24'h100000, FSCALE_RST);
        cal(MODE_SFS, 0, 0, 0, 0, 0, 10'h061, 24'h600000, 8'd4, REF_EXT, 24'h100000, 24'h500000);
        cal(MODE_IFS, 0, 0, 1, 0, 0, 10'h060, 24'h500000, 8'd3, REF_FULL, 24'h100000, 24'h400000);
        cal(MODE_IFS, 0, 0, 1, 1, 0, 10'h060, 24'h480000, 8'd6, REF_FULL, 24'h100000, 24'h380000);
        cal(MODE_IFS, 0, 0, 1, 1, 1, 10'h060, 24'h300000, 8'd12, REF_FULL, 24'h100000, 24'h200000);
        cal(MODE_SFS, 1, 0, 0, 0, 0, 10'h061, 24'h200000, 8'd4, REF_EXT, 24'h200000, 24'h000000);
        chk({prev_code, last_code}, {MODE_SZS, MODE_SFS});
        refuse(MODE_IFS, 10'h061);
        refuse(MODE_PWRDN, 10'h060);
        cw(COEF_SEL_OFFSET, 24'h0A5C3E);
        cw(COEF_SEL_FSCALE, 24'h3C1F07);
        // Unity step above offset yields the gain word; below offset clamps
        conv(24'h4A5C3E, 24'h3C1F07);
        conv(24'h000100, 24'h000000);
        final_report();
    end

    initial begin
        #160000;
        miscompares++;
        final_report();
    end
endmodule : adc_calibration_sequencer_tb
`default_nettype wire
